// File: hdl/udic_pkg.sv
package udic_pkg;

	localparam int unsigned MAX_EP       = 9;
	localparam int unsigned DMA_CH       = 6;
	localparam int unsigned EP_MASK_W    = 7;

	// register byte offsets
	localparam logic [7:0] OFS_GSTAT     = 8'h00;
	localparam logic [7:0] OFS_GMASK     = 8'h04;
	localparam logic [7:0] OFS_GCLR      = 8'h08;
	localparam logic [7:0] OFS_EPCTL     = 8'h0c;
	localparam logic [7:0] OFS_EPSEL     = 8'h10;
	localparam logic [7:0] OFS_EPMSET    = 8'h14;
	localparam logic [7:0] OFS_EPMCLR    = 8'h18;
	localparam logic [7:0] OFS_EPMASK    = 8'h1c;
	localparam logic [7:0] OFS_EPSTAT    = 8'h20;
	localparam logic [7:0] OFS_EPSCLR    = 8'h24;
	localparam logic [7:0] OFS_CLKCTL    = 8'h28;

	// global status and endpoint control field positions
	localparam int unsigned BIT_SUSPEND_FLAG     = 0;
	localparam int unsigned BIT_MSOF     = 1;
	localparam int unsigned BIT_SOF      = 2;
	localparam int unsigned BIT_END_OF_BUS_RESET_FLAG    = 3;
	localparam int unsigned BIT_WAKE     = 4;
	localparam int unsigned BIT_END_OF_RESUME_FLAG    = 5;
	localparam int unsigned BIT_UPSTREAM_RESUME_FLAG    = 6;
	localparam int unsigned POS_PEP      = 12;
	localparam int unsigned POS_DMA      = 25;
	localparam int unsigned POS_EPRST    = 16;
	localparam int unsigned POS_EPEN     = 0;

	// endpoint mask field positions
	localparam int unsigned EM_MDATA     = 0;
	localparam int unsigned EM_SHORT     = 1;
	localparam int unsigned EM_STALL     = 2;
	localparam int unsigned EM_CRC       = 3;
	localparam int unsigned EM_OVERF     = 4;
	localparam int unsigned EM_NAKIN     = 5;
	localparam int unsigned EM_HBISO     = 6;
	localparam int unsigned EM_TOGGLE_RESET_REQUEST     = 7;

	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

	// line activity must persist this long before it counts as a wake
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned WAKE_FILT_NS    = 50;
	localparam int unsigned WAKE_FILT_CYC   =
		(WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} udic_wb_req_t;

endpackage : udic_pkg

// File: hdl/udic_ctrl.sv
`timescale 1ns/1ps
// Function
// - DMA summary bit x follows channel x interrupt, drops when channel source clears.
// - Endpoint summary bit x set by endpoint interrupt, clears once source serviced.
// - Status bits raise interrupt output only where device mask bit is one.
// - Upstream resume flag set on sending resume; write-one clear needs clocks enabled.
// - End-of-resume flag set on host end of resume; write-one clears it.
// - Wake flag set by filtered line activity, not own resume; cleared by write with clocks enabled, or by suspend.
// - Wake detection works even while the USB clock is frozen.
// - End-of-bus-reset flag set at end of USB reset; write-one clears it.
// - Endpoint reset clears FIFO, status and mask, keeps endpoint configuration.
// - Endpoint reset spares data toggle; toggle reset only by its own request.
// - Endpoint held in reset stays configured and enabled.
// - Writing zero to endpoint reset ends it and FIFO use resumes.
// - USB bus reset clears every endpoint reset bit.
// - Disabled endpoint is inactive, unanswering, status and mask cleared.
// - Endpoint mask bits set by enable-set writes, cleared by enable-clear writes.
// - Short packet forced at DMA end for non-control IN with mask, end-buffer, autoswitch.
module udic_ctrl
	import udic_pkg::*;
#(
	parameter int unsigned NUM_EP   = MAX_EP,
	parameter int unsigned FILT_CYC = WAKE_FILT_CYC
)(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire udic_wb_req_t                  wb_req_i,
	output logic                               wb_ack_o,
	output logic [31:0]                        wb_dat_o,
	output logic                               irq_o,
	input  wire logic [DMA_CH-1:0]             dma_irq_i,
	input  wire logic [NUM_EP-1:0][EP_MASK_W-1:0] ep_evt_i,
	input  wire logic                          suspend_evt_i,
	input  wire logic                          sof_evt_i,
	input  wire logic                          msof_evt_i,
	input  wire logic                          bus_reset_end_evt_i,
	input  wire logic                          end_of_resume_evt_i,
	input  wire logic                          upstream_resume_evt_i,
	input  wire logic                          upstream_resume_busy_i,
	input  wire logic                          line_nonidle_i,
	input  wire logic [NUM_EP-1:0]             ep_is_in_i,
	input  wire logic [NUM_EP-1:0]             ep_is_ctrl_i,
	input  wire logic [NUM_EP-1:0]             ep_end_buf_en_i,
	input  wire logic [NUM_EP-1:0]             ep_auto_bank_switch_i,
	input  wire logic [NUM_EP-1:0]             ep_dma_end_i,
	output logic [NUM_EP-1:0]                  ep_active_o,
	output logic [NUM_EP-1:0]                  ep_machine_rst_o,
	output logic [NUM_EP-1:0]                  ep_toggle_rst_o,
	output logic [NUM_EP-1:0]                  ep_force_short_o,
	output logic                               usb_clk_en_o
);

	// the register layout has room for nine endpoints and an 8-bit filter count
	if (NUM_EP < 1 || NUM_EP > MAX_EP)
	begin : g_bad_num_ep
		$error("NUM_EP out of range");
	end
	if (FILT_CYC < 1 || FILT_CYC > 255)
	begin : g_bad_filt_cyc
		$error("FILT_CYC out of range");
	end

	function automatic logic [31:0] apply_sel(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction : apply_sel

	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : sel_mask

	// bus decode
	logic                ack_reg;
	logic [31:0]         rdat_reg;
	wire logic           acc      = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
	wire logic           wr       = acc & wb_req_i.we;
	wire logic [31:0]    wmask    = sel_mask(wb_req_i.sel);
	wire logic [31:0]    wones    = wb_req_i.dat & wmask;
	wire logic           wr_gmask = wr & (wb_req_i.adr == OFS_GMASK);
	wire logic           wr_gclr  = wr & (wb_req_i.adr == OFS_GCLR);
	wire logic           wr_epctl = wr & (wb_req_i.adr == OFS_EPCTL);
	wire logic           wr_epsel = wr & (wb_req_i.adr == OFS_EPSEL);
	wire logic           wr_emset = wr & (wb_req_i.adr == OFS_EPMSET);
	wire logic           wr_emclr = wr & (wb_req_i.adr == OFS_EPMCLR);
	wire logic           wr_esclr = wr & (wb_req_i.adr == OFS_EPSCLR);
	wire logic           wr_clk   = wr & (wb_req_i.adr == OFS_CLKCTL);

	// control state
	logic [31:0]         gmask_reg;
	logic [6:0]          gflag_reg;
	logic [6:0]          gflag_next;
	logic [NUM_EP-1:0]   ep_en_reg;
	logic [NUM_EP-1:0]   ep_rst_reg;
	logic [3:0]          ep_sel_reg;
	logic                freeze_reg;
	logic [EP_MASK_W-1:0] ep_mask_reg [NUM_EP];
	logic [EP_MASK_W-1:0] ep_stat_reg [NUM_EP];
	logic [NUM_EP-1:0]   toggle_req_reg;

	// line activity synchroniser and glitch filter on the free-running clock
	logic                line_s1_reg;
	logic                line_s2_reg;
	logic [7:0]          filt_cnt_reg;
	logic                wake_seen_reg;
	wire logic           filt_full = (filt_cnt_reg == 8'(FILT_CYC));
	wire logic           wake_set  = filt_full & ~wake_seen_reg & ~upstream_resume_busy_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			line_s1_reg <= 1'b0;
			line_s2_reg <= 1'b0;
		end
		else
		begin
			line_s1_reg <= line_nonidle_i;
			line_s2_reg <= line_s1_reg;
		end
	end

	// not gated by freeze: the wake path must see the lines while clocks sleep
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt_cnt_reg  <= 8'h00;
			wake_seen_reg <= 1'b0;
		end
		else
		begin
			if (!line_s2_reg)
				filt_cnt_reg <= 8'h00;
			else if (!filt_full)
				filt_cnt_reg <= filt_cnt_reg + 8'h01;
			wake_seen_reg <= filt_full;
		end
	end

	// sticky event flags: a set in the clearing cycle wins
	wire logic [6:0] evt_set = {
		upstream_resume_evt_i,
		end_of_resume_evt_i,
		wake_set,
		bus_reset_end_evt_i,
		sof_evt_i,
		msof_evt_i,
		suspend_evt_i
	};
	wire logic [6:0] clr_req = wr_gclr ? wones[6:0] : 7'h00;
	// flags living on the USB clock only accept their clear while it runs
	wire logic [6:0] clr_eff = clr_req
		& ~({7{freeze_reg}} & 7'h50);

	always_comb
	begin
		gflag_next = (gflag_reg & ~clr_eff) | evt_set;
		if (suspend_evt_i && !wake_set)
			gflag_next[BIT_WAKE] = 1'b0;
	end

	// summary vectors
	logic [9:0] pep_vec;
	always_comb
	begin
		pep_vec = 10'h000;
		for (int i = 0; i < NUM_EP; i++)
			pep_vec[i] = |(ep_stat_reg[i] & ep_mask_reg[i]);
	end

	wire logic [31:0] gstat = {1'b0, dma_irq_i, 3'h0, pep_vec, 5'h00,
		gflag_reg};
	wire logic [3:0] sel_ep = ep_sel_reg;
	wire logic       sel_ok = (32'(sel_ep) < NUM_EP);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gflag_reg <= 7'h00;
		else
			gflag_reg <= gflag_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gmask_reg <= RST_ZERO;
		else if (wr_gmask)
			gmask_reg <= apply_sel(gmask_reg, wb_req_i.dat, wb_req_i.sel);
	end

	// selector and freeze live in the low byte lane only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ep_sel_reg <= 4'h0;
		else if (wr_epsel && wb_req_i.sel[0])
			ep_sel_reg <= wb_req_i.dat[3:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			freeze_reg <= 1'b0;
		else if (wr_clk && wb_req_i.sel[0])
			freeze_reg <= wb_req_i.dat[0];
	end

	// endpoint enable and reset controls
	wire logic [31:0] epctl_rd = (32'(ep_rst_reg) << POS_EPRST)
		| (32'(ep_en_reg) << POS_EPEN);
	wire logic [31:0] epctl_wr = apply_sel(epctl_rd, wb_req_i.dat, wb_req_i.sel);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ep_en_reg  <= '0;
			ep_rst_reg <= '0;
		end
		else
		begin
			if (wr_epctl)
			begin
				ep_en_reg  <= epctl_wr[POS_EPEN +: NUM_EP];
				ep_rst_reg <= epctl_wr[POS_EPRST +: NUM_EP];
			end
			if (bus_reset_end_evt_i)
				ep_rst_reg <= '0;
		end
	end

	// per-endpoint masks, status and toggle reset requests
	for (genvar g = 0; g < NUM_EP; g++)
	begin : g_ep
		wire logic hit  = sel_ok & (sel_ep == 4'(g));
		// reset or disable wipes status and mask, never enable or configuration
		wire logic wipe = ep_rst_reg[g] | ~ep_en_reg[g];

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				ep_mask_reg[g]    <= '0;
				ep_stat_reg[g]    <= '0;
				toggle_req_reg[g] <= 1'b0;
			end
			else if (wipe)
			begin
				ep_mask_reg[g]    <= '0;
				ep_stat_reg[g]    <= '0;
				// toggle request still honoured: endpoint reset spares the toggle
				toggle_req_reg[g] <= hit & wr_emset & wones[EM_TOGGLE_RESET_REQUEST];
			end
			else
			begin
				if (hit && wr_emset)
					ep_mask_reg[g] <= ep_mask_reg[g] | wones[EP_MASK_W-1:0];
				else if (hit && wr_emclr)
					ep_mask_reg[g] <= ep_mask_reg[g] & ~wones[EP_MASK_W-1:0];
				ep_stat_reg[g] <= (ep_stat_reg[g]
					& ~((hit & wr_esclr) ? wones[EP_MASK_W-1:0] : '0))
					| ep_evt_i[g];
				toggle_req_reg[g] <= hit & wr_emset & wones[EM_TOGGLE_RESET_REQUEST];
			end
		end
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		case (wb_req_i.adr)
			OFS_GSTAT:  rd_mux = gstat;
			OFS_GMASK:  rd_mux = gmask_reg;
			OFS_EPCTL:  rd_mux = epctl_rd;
			OFS_EPSEL:  rd_mux = {28'h0, ep_sel_reg};
			OFS_EPMASK: rd_mux = sel_ok ? 32'(ep_mask_reg[sel_ep]) : 32'h0;
			OFS_EPSTAT: rd_mux = sel_ok ? 32'(ep_stat_reg[sel_ep]) : 32'h0;
			OFS_CLKCTL: rd_mux = {31'h0, freeze_reg};
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	// one-cycle answer; unmapped and write-only offsets read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= acc;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_reg <= 32'h0000_0000;
		else
			rdat_reg <= (acc && !wb_req_i.we) ? rd_mux : 32'h0000_0000;
	end

	// outputs, all registered
	logic                irq_reg;
	logic [NUM_EP-1:0]   active_reg;
	logic [NUM_EP-1:0]   mrst_reg;
	logic [NUM_EP-1:0]   short_reg;
	logic                clk_en_reg;
	logic [NUM_EP-1:0]   short_mask;

	always_comb
	begin
		for (int i = 0; i < NUM_EP; i++)
			short_mask[i] = ep_mask_reg[i][EM_SHORT];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(gstat & gmask_reg);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			active_reg <= '0;
		else
			active_reg <= ep_en_reg;
	end

	// a disabled endpoint is held in reset too, so it never answers the host
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mrst_reg <= '1;
		else
			mrst_reg <= ep_rst_reg | ~ep_en_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			short_reg <= '0;
		else
			short_reg <= short_mask & ep_is_in_i & ~ep_is_ctrl_i & ep_end_buf_en_i
				& ep_auto_bank_switch_i & ep_dma_end_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clk_en_reg <= 1'b1;
		else
			clk_en_reg <= ~freeze_reg;
	end

	assign wb_ack_o         = ack_reg;
	assign wb_dat_o         = rdat_reg;
	assign irq_o            = irq_reg;
	assign ep_active_o      = active_reg;
	assign ep_machine_rst_o = mrst_reg;
	assign ep_toggle_rst_o  = toggle_req_reg;
	assign ep_force_short_o = short_reg;
	assign usb_clk_en_o     = clk_en_reg;

endmodule : udic_ctrl

// File: verif/udic_host_model.sv
`timescale 1ns/1ps
module udic_host_model (
	input  wire logic       clk_i,
	output logic      [6:0] ev_o,
	output logic            line_o
);
	initial ev_o = '0;
	initial line_o = 1'b0;
	// one clock per bus event, indexed like the status bits
	task pulse(input int b);
		@(posedge clk_i);
		ev_o[b] <= 1'b1;
		@(posedge clk_i);
		ev_o <= '0;
	endtask : pulse
	// line returns to idle between bursts
	task burst(input int n);
		@(posedge clk_i);
		line_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		line_o <= 1'b0;
	endtask : burst
endmodule : udic_host_model

// File: verif/udic_ctrl_props.sv
`timescale 1ns/1ps
module udic_ctrl_props
	import udic_pkg::*;
#(
	parameter int unsigned NUM_EP = MAX_EP
)(
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire udic_wb_req_t        wb_req_i,
	input wire logic                wb_ack_o,
	input wire logic [31:0]         wb_dat_o,
	input wire logic [DMA_CH-1:0]   dma_irq_i,
	input wire logic                bus_reset_end_evt_i,
	input wire logic [NUM_EP-1:0]   ep_is_in_i,
	input wire logic [NUM_EP-1:0]   ep_is_ctrl_i,
	input wire logic [NUM_EP-1:0]   ep_end_buf_en_i,
	input wire logic [NUM_EP-1:0]   ep_auto_bank_switch_i,
	input wire logic [NUM_EP-1:0]   ep_dma_end_i,
	input wire logic [NUM_EP-1:0]   ep_active_o,
	input wire logic [NUM_EP-1:0]   ep_machine_rst_o,
	input wire logic [NUM_EP-1:0]   ep_toggle_rst_o,
	input wire logic [NUM_EP-1:0]   ep_force_short_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [NUM_EP-1:0] qual;
	logic              rd_st;
	assign qual = ep_dma_end_i & ep_is_in_i & ~ep_is_ctrl_i & ep_end_buf_en_i
		& ep_auto_bank_switch_i;
	assign rd_st = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~wb_ack_o
		& (wb_req_i.adr == OFS_GSTAT);
	property p_ack_once;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == '0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
	property p_dma_live;
		rd_st && $stable(dma_irq_i) |=> wb_dat_o[30:25] == $past(dma_irq_i);
	endproperty
	a_dma_live: assert property (p_dma_live) else $error("dma summary wrong");
	property p_rsv_zero;
		rd_st |=> (wb_dat_o & 32'h81c0_0f80) == '0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
	property p_dis_rst;
		(~ep_active_o & ~ep_machine_rst_o) == '0;
	endproperty
	a_dis_rst: assert property (p_dis_rst) else $error("disabled ep not reset");
	property p_bus_rst;
		bus_reset_end_evt_i ##0 (!wb_req_i.cyc)[*3] |-> ep_machine_rst_o == ~ep_active_o;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("ep reset kept");
	property p_tgl;
		|ep_toggle_rst_o |-> wb_ack_o ##1 ep_toggle_rst_o == '0;
	endproperty
	a_tgl: assert property (p_tgl) else $error("toggle reset stray");
	property p_short;
		(ep_force_short_o & ~$past(qual)) == '0;
	endproperty
	a_short: assert property (p_short) else $error("short packet stray");
	property p_act_chg;
		$changed(ep_active_o) |-> wb_ack_o || $past(wb_ack_o);
	endproperty
	a_act_chg: assert property (p_act_chg) else $error("enable moved alone");
endmodule : udic_ctrl_props
bind udic_ctrl udic_ctrl_props #(.NUM_EP(NUM_EP)) u_props (.clk_i, .rst_i, .wb_req_i,
	.wb_ack_o, .wb_dat_o, .dma_irq_i, .bus_reset_end_evt_i, .ep_is_in_i, .ep_is_ctrl_i,
	.ep_end_buf_en_i, .ep_auto_bank_switch_i, .ep_dma_end_i, .ep_active_o,
	.ep_machine_rst_o, .ep_toggle_rst_o, .ep_force_short_o);

// File: verif/udic_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module udic_ctrl_bench
	import udic_pkg::*;
;
	localparam int FC = 2;
	logic                          clk_i, rst_i, ack, irq, up_rsm, up_busy, clk_en, line;
	udic_wb_req_t                  req;
	logic [31:0]                   dat, q;
	logic [5:0]                    dma;
	logic [6:0]                    ev;
	logic [MAX_EP-1:0][EP_MASK_W-1:0] evt;
	logic [MAX_EP-1:0]             is_in, is_ctl, eob, asw, dend, act, mrst, tgl, fsh;
	int                            fails = 0, total_checks = 0;
	int                            bits[6] = '{0, 1, 2, 3, 5, 6};
	udic_ctrl #(.FILT_CYC(FC)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
		.wb_ack_o(ack), .wb_dat_o(dat), .irq_o(irq), .dma_irq_i(dma), .ep_evt_i(evt),
		.suspend_evt_i(ev[BIT_SUSPEND_FLAG]), .sof_evt_i(ev[BIT_SOF]), .msof_evt_i(ev[BIT_MSOF]),
		.bus_reset_end_evt_i(ev[BIT_END_OF_BUS_RESET_FLAG]), .end_of_resume_evt_i(ev[BIT_END_OF_RESUME_FLAG]),
		.upstream_resume_evt_i(up_rsm), .upstream_resume_busy_i(up_busy),
		.line_nonidle_i(line), .ep_is_in_i(is_in), .ep_is_ctrl_i(is_ctl),
		.ep_end_buf_en_i(eob), .ep_auto_bank_switch_i(asw), .ep_dma_end_i(dend),
		.ep_active_o(act), .ep_machine_rst_o(mrst), .ep_toggle_rst_o(tgl),
		.ep_force_short_o(fsh), .usb_clk_en_o(clk_en));
	udic_host_model host (.clk_i(clk_i), .ev_o(ev), .line_o(line));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task stop_test;
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= {1'b1, 1'b1, w, a, 4'hf, d};
		do
		begin
			@(posedge clk_i);
		end
		while (ack !== 1'b1);
		q = dat;
		req <= '0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, '0);
		`CHK(q, e)
	endtask : rd
	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle
	task dma_end(input logic [MAX_EP-1:0] e);
		@(posedge clk_i);
		dend[2] <= 1'b1;
		@(posedge clk_i);
		dend <= '0;
		@(posedge clk_i);
		`CHK(fsh, e)
	endtask : dma_end
	task t_dma;
		rd(OFS_GMASK, '0);
		rd(OFS_EPCTL, '0);
		@(posedge clk_i);
		dma <= 6'h2d;
		wb(1'b1, OFS_GSTAT, 32'hffff_ffff);
		rd(OFS_GSTAT, 32'h5a00_0000);
		rd(8'h3c, '0);
		wb(1'b1, OFS_GMASK, 32'h0200_0000);
		idle(2);
		`CHK(irq, 1'b1)
		@(posedge clk_i);
		dma <= '0;
		idle(3);
		`CHK(irq, 1'b0)
	endtask : t_dma
	task t_flags;
		foreach (bits[i])
		begin
			wb(1'b1, OFS_GMASK, '0);
			if (bits[i] == BIT_UPSTREAM_RESUME_FLAG)
			begin
				@(posedge clk_i);
				up_rsm <= 1'b1;
				@(posedge clk_i);
				up_rsm <= 1'b0;
			end
			else
				host.pulse(bits[i]);
			idle(2);
			`CHK(irq, 1'b0)
			rd(OFS_GSTAT, 32'h1 << bits[i]);
			wb(1'b1, OFS_GMASK, 32'h1 << bits[i]);
			idle(2);
			`CHK(irq, 1'b1)
			wb(1'b1, OFS_GCLR, 32'h1 << bits[i]);
			rd(OFS_GSTAT, '0);
		end
	endtask : t_flags
	task t_wake;
		host.burst(FC + 6);
		idle(3);
		rd(OFS_GSTAT, 32'h10);
		wb(1'b1, OFS_CLKCTL, 32'h1);
		wb(1'b1, OFS_GCLR, 32'h10);
		rd(OFS_GSTAT, 32'h10);
		host.pulse(BIT_SUSPEND_FLAG);
		rd(OFS_GSTAT, 32'h1);
		host.burst(FC + 6);
		idle(3);
		rd(OFS_GSTAT, 32'h11);
		`CHK(clk_en, 1'b0)
		wb(1'b1, OFS_CLKCTL, '0);
		wb(1'b1, OFS_GCLR, 32'h11);
		up_busy <= 1'b1;
		host.burst(FC + 6);
		idle(4);
		up_busy <= 1'b0;
		rd(OFS_GSTAT, '0);
	endtask : t_wake
	task t_ep;
		wb(1'b1, OFS_EPCTL, 32'h4);
		idle(2);
		`CHK(mrst[2], 1'b0)
		wb(1'b1, OFS_EPSEL, 32'h2);
		wb(1'b1, OFS_EPMSET, 32'h7f);
		rd(OFS_EPMASK, 32'h7f);
		wb(1'b1, OFS_EPMCLR, 32'h7d);
		rd(OFS_EPMASK, 32'h2);
		@(posedge clk_i);
		evt[2][EM_SHORT] <= 1'b1;
		@(posedge clk_i);
		evt <= '0;
		rd(OFS_GSTAT, 32'h1 << (POS_PEP + 2));
		wb(1'b1, OFS_EPSCLR, 32'h2);
		rd(OFS_GSTAT, '0);
		dma_end(9'h004);
		is_ctl[2] <= 1'b1;
		dma_end('0);
		wb(1'b1, OFS_EPCTL, 32'h0004_0004);
		`CHK(tgl, 9'h000)
		wb(1'b1, OFS_EPMSET, 32'hff);
		`CHK(tgl, 9'h004)
		rd(OFS_EPMASK, '0);
		`CHK({act[2], mrst[2]}, 2'b11)
		wb(1'b1, OFS_EPCTL, 32'h4);
		idle(2);
		`CHK(mrst[2], 1'b0)
		wb(1'b1, OFS_EPCTL, 32'h0004_0004);
		host.pulse(BIT_END_OF_BUS_RESET_FLAG);
		idle(3);
		rd(OFS_EPCTL, 32'h4);
		wb(1'b1, OFS_EPCTL, '0);
		idle(2);
		`CHK({act[2], mrst[2]}, 2'b01)
	endtask : t_ep
	initial
	begin
		rst_i = 1'b1;
		{req, dma, evt, up_rsm, up_busy, is_ctl, dend} = '0;
		{is_in, eob, asw} = '1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_dma;
		t_flags;
		t_wake;
		t_ep;
		stop_test;
	end
	// generous bound: the sequence needs a few hundred cycles
	initial
	begin
		#200000;
		fails++;
		stop_test;
	end
endmodule : udic_ctrl_bench
